// >>> dwc_pkg.sv
// constants and carriers shared by the display window configuration block
package dwc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_VACT_LO = 8'h1a;
    localparam logic [7:0] OFF_VACT_HI = 8'h1b;
    localparam logic [7:0] OFF_VS_START = 8'h1e;
    localparam logic [7:0] OFF_VS_PULSE = 8'h1f;
    localparam logic [7:0] OFF_MBASE0 = 8'h20;
    localparam logic [7:0] OFF_MBASE1 = 8'h21;
    localparam logic [7:0] OFF_MBASE2 = 8'h22;
    localparam logic [7:0] OFF_MBASE3 = 8'h23;
    localparam logic [7:0] OFF_MWID_LO = 8'h24;
    localparam logic [7:0] OFF_MWID_HI = 8'h25;
    localparam logic [7:0] OFF_MX_LO = 8'h26;
    localparam logic [7:0] OFF_MX_HI = 8'h27;
    localparam logic [7:0] OFF_MY_LO = 8'h28;
    localparam logic [7:0] OFF_MY_HI = 8'h29;
    localparam logic [7:0] OFF_IX_LO = 8'h2a;
    localparam logic [7:0] OFF_IX_HI = 8'h2b;
    localparam logic [7:0] OFF_IY_LO = 8'h2c;
    localparam logic [7:0] OFF_IY_HI = 8'h2d;
    localparam logic [7:0] OFF_IBASE0 = 8'h2e;
    localparam logic [7:0] OFF_IBASE1 = 8'h2f;
    localparam logic [7:0] OFF_IBASE2 = 8'h30;
    localparam logic [7:0] OFF_IBASE3 = 8'h31;
    localparam logic [7:0] STAGE_FIRST = 8'h1a;
    localparam logic [7:0] STAGE_LAST = 8'h31;
    // field layout
    localparam int COORD_HI_MSB = 4;
    localparam int VACT_HI_MSB = 2;
    localparam int ALIGN_W = 2;
    // reset values
    localparam logic [7:0] RST_VS_START = 8'h0b;
    localparam logic [5:0] RST_VS_PULSE = 6'h00;
    localparam logic [10:0] RST_VACT = 11'h0df;

    typedef struct packed {
        logic [31:0] main_base;
        logic [12:0] main_width;
        logic [12:0] main_x;
        logic [12:0] main_y;
        logic [7:0] vs_start;
        logic [5:0] vs_pulse;
        logic [10:0] vact;
    } dwc_cfg_t;

    typedef struct packed {
        logic [12:0] x;
        logic [12:0] y;
        logic [31:0] base;
    } dwc_inset_t;

    typedef enum {ST_ACTIVE, ST_FRONT, ST_SYNC, ST_BACK} dwc_vstate_t;
endpackage

// >>> dwc_vsync.sv
// vertical line sequencer: active area, front porch, sync pulse, back porch
`timescale 1ns/100ps
module dwc_vsync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic line_strobe,
    input wire dwc_pkg::dwc_cfg_t cfg,
    input wire logic [9:0] back_lines,
    output logic vsync,
    output logic active,
    output logic line_begin,
    output logic frame_start,
    output logic [10:0] row
);
    dwc_pkg::dwc_vstate_t state, next_state;
    logic [10:0] cnt, next_cnt;
    logic done;
    logic [11:0] seg_n;

    // ----------------------------------------
    // segment sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        case (state)
            dwc_pkg::ST_ACTIVE: done = (cnt == cfg.vact);
            dwc_pkg::ST_FRONT: done = (cnt == {3'h0, cfg.vs_start});
            dwc_pkg::ST_SYNC: done = (cnt == {5'h00, cfg.vs_pulse});
            dwc_pkg::ST_BACK: done = (cnt == {1'b0, back_lines});
            default: done = 1'b1;
        endcase
        if (line_strobe) begin
            next_cnt = done ? 11'h000 : cnt + 11'h001;
            if (done) begin
                case (state)
                    dwc_pkg::ST_ACTIVE: next_state = dwc_pkg::ST_FRONT;
                    dwc_pkg::ST_FRONT: next_state = dwc_pkg::ST_SYNC;
                    dwc_pkg::ST_SYNC: next_state = dwc_pkg::ST_BACK;
                    default: next_state = dwc_pkg::ST_ACTIVE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state <= dwc_pkg::ST_ACTIVE;
            cnt <= 11'h000;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // outputs are registered copies of the next segment
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            vsync <= 1'b0;
            active <= 1'b0;
            line_begin <= 1'b0;
            frame_start <= 1'b0;
            row <= 11'h000;
        end else begin
            vsync <= (next_state == dwc_pkg::ST_SYNC);
            active <= (next_state == dwc_pkg::ST_ACTIVE);
            line_begin <= line_strobe && (next_state == dwc_pkg::ST_ACTIVE);
            frame_start <= line_strobe && done && (state == dwc_pkg::ST_BACK);
            row <= next_cnt;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // strobes seen in the current segment, counted apart from cnt
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            seg_n <= 12'h000;
        end else if (next_state != state) begin
            seg_n <= 12'h000;
        end else if (line_strobe) begin
            seg_n <= seg_n + 12'h001;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_vs_start;
        $rose(vsync) |-> $past(seg_n) == {4'h0, $past(cfg.vs_start)};
    endproperty
    a_vs_start: assert property (p_vs_start)
        else $error("vsync began after wrong number of front lines");

    property p_vs_width;
        $fell(vsync) |-> $past(seg_n) == {6'h00, $past(cfg.vs_pulse)};
    endproperty
    a_vs_width: assert property (p_vs_width)
        else $error("vsync pulse held for wrong number of lines");

    property p_vact;
        $fell(active) |-> ##0 !vsync ##0 $past(seg_n) == {1'b0, $past(cfg.vact)};
    endproperty
    a_vact: assert property (p_vact)
        else $error("active area lasted wrong number of lines");

    c_vsync: cover property ($rose(vsync));
    c_frame: cover property (frame_start && line_begin);
endmodule

// >>> dwc_fetch.sv
// row start address generator for the main window
`timescale 1ns/100ps
module dwc_fetch #(
    parameter int PIXEL_BYTES = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic line_begin,
    input wire logic [10:0] row,
    input wire dwc_pkg::dwc_cfg_t cfg,
    output logic [31:0] row_addr,
    output logic row_addr_valid
);
    if (PIXEL_BYTES < 1 || PIXEL_BYTES > 4) begin : g_chk
        $error("PIXEL_BYTES must be 1 to 4");
    end

    // address of the first window pixel of a canvas row
    function automatic logic [31:0] row_start(input dwc_pkg::dwc_cfg_t c,
                                              input logic [10:0] r);
        logic [13:0] line;
        logic [27:0] pix;
        line = {1'b0, c.main_y} + {3'h0, r};
        pix = 28'(line * c.main_width) + {15'h0000, c.main_x};
        return c.main_base + 32'(pix) * 32'(PIXEL_BYTES);
    endfunction

    // ----------------------------------------
    // row address
    // ----------------------------------------
    // base plus row stride
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            row_addr <= 32'h0000_0000;
            row_addr_valid <= 1'b0;
        end else begin
            row_addr_valid <= line_begin;
            if (line_begin) begin
                row_addr <= row_start(cfg, row);
            end
        end
    end
endmodule

// >>> dwc_top.sv
// display window configuration: byte registers, vertical timing, fetch origin
`timescale 1ns/100ps
// Summary of operation
// - vsync starts start-field plus one lines after the active area ends.
// - vsync lasts six-bit width field plus one lines.
// - main image base is built from bytes 20h (low) to 23h (high).
// - main image width is 13 bits, low byte plus five bits; low two zero.
// - main origin X is 13 bits over two bytes; low two bits zero.
// - main origin Y is 13 bits, 0 to 8,191, any low bits.
// - inset origin X is 13 bits over two bytes; low two bits zero.
// - inset origin and base registers reach only the selected inset window.
// - inset base is 32 bits from 2Eh (low) to 31h; low two zero.
// - multi-byte values take effect only when their highest byte is written.
// - display height is the eleven-bit field plus one lines.
module dwc_top #(
    parameter int PIXEL_BYTES = 2
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic inset_sel,
    input wire logic line_strobe,
    input wire logic [9:0] back_lines,
    output logic vsync,
    output logic active,
    output logic frame_start,
    output logic [31:0] row_addr,
    output logic row_addr_valid,
    output dwc_pkg::dwc_cfg_t cfg,
    output dwc_pkg::dwc_inset_t inset0,
    output dwc_pkg::dwc_inset_t inset1
);
    logic [7:0] stage [dwc_pkg::STAGE_FIRST:dwc_pkg::STAGE_LAST];
    dwc_pkg::dwc_inset_t inset_set [2];
    dwc_pkg::dwc_inset_t inset_cur;
    logic [7:0] next_rdata;
    logic line_begin;
    logic [10:0] row;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic is_top(input logic [7:0] a);
        case (a)
            dwc_pkg::OFF_VACT_HI,
            dwc_pkg::OFF_MBASE3,
            dwc_pkg::OFF_MWID_HI,
            dwc_pkg::OFF_MX_HI,
            dwc_pkg::OFF_MY_HI,
            dwc_pkg::OFF_IX_HI,
            dwc_pkg::OFF_IY_HI,
            dwc_pkg::OFF_IBASE3: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // 13-bit pixel value from a high and low byte, optionally four-aligned
    function automatic logic [12:0] coord(input logic [7:0] hi, input logic [7:0] lo,
                                          input logic aligned);
        logic [1:0] low2;
        low2 = aligned ? 2'b00 : lo[dwc_pkg::ALIGN_W-1:0];
        return {hi[dwc_pkg::COORD_HI_MSB:0], lo[7:dwc_pkg::ALIGN_W], low2};
    endfunction

    function automatic logic [31:0] word(input logic [7:0] b3, input logic [7:0] b2,
                                         input logic [7:0] b1, input logic [7:0] b0);
        return {b3, b2, b1, b0[7:dwc_pkg::ALIGN_W], 2'b00};
    endfunction

    // ----------------------------------------
    // low byte staging
    // ----------------------------------------
    // hold low bytes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = dwc_pkg::STAGE_FIRST; i <= dwc_pkg::STAGE_LAST; i++) begin
                stage[i] <= 8'h00;
            end
        end else if (reg_wr && !is_top(reg_addr) && reg_addr >= dwc_pkg::STAGE_FIRST
                     && reg_addr <= dwc_pkg::STAGE_LAST) begin
            stage[reg_addr] <= reg_wdata;
        end
    end

    // ----------------------------------------
    // vertical timing settings
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg.vs_start <= dwc_pkg::RST_VS_START;
            cfg.vs_pulse <= dwc_pkg::RST_VS_PULSE;
            cfg.vact <= dwc_pkg::RST_VACT;
        end else if (reg_wr) begin
            case (reg_addr)
                dwc_pkg::OFF_VS_START: cfg.vs_start <= reg_wdata;
                dwc_pkg::OFF_VS_PULSE: cfg.vs_pulse <= reg_wdata[5:0];
                dwc_pkg::OFF_VACT_HI: begin
                    cfg.vact <= {reg_wdata[dwc_pkg::VACT_HI_MSB:0],
                                 stage[dwc_pkg::OFF_VACT_LO]};
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // main window settings
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cfg.main_base <= 32'h0000_0000;
            cfg.main_width <= 13'h0000;
            cfg.main_x <= 13'h0000;
            cfg.main_y <= 13'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                dwc_pkg::OFF_MBASE3: begin
                    cfg.main_base <= word(reg_wdata, stage[dwc_pkg::OFF_MBASE2],
                                          stage[dwc_pkg::OFF_MBASE1],
                                          stage[dwc_pkg::OFF_MBASE0]);
                end
                dwc_pkg::OFF_MWID_HI: begin
                    cfg.main_width <= coord(reg_wdata, stage[dwc_pkg::OFF_MWID_LO], 1'b1);
                end
                dwc_pkg::OFF_MX_HI: begin
                    cfg.main_x <= coord(reg_wdata, stage[dwc_pkg::OFF_MX_LO], 1'b1);
                end
                dwc_pkg::OFF_MY_HI: begin
                    cfg.main_y <= coord(reg_wdata, stage[dwc_pkg::OFF_MY_LO], 1'b0);
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // inset window settings
    // ----------------------------------------
    // both inset windows share one register window; the select input steers it
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            inset_set[0] <= '0;
            inset_set[1] <= '0;
        end else if (reg_wr) begin
            case (reg_addr)
                dwc_pkg::OFF_IX_HI: begin
                    inset_set[inset_sel].x <= coord(reg_wdata, stage[dwc_pkg::OFF_IX_LO],
                                                    1'b1);
                end
                dwc_pkg::OFF_IY_HI: begin
                    inset_set[inset_sel].y <= coord(reg_wdata, stage[dwc_pkg::OFF_IY_LO],
                                                    1'b0);
                end
                dwc_pkg::OFF_IBASE3: begin
                    inset_set[inset_sel].base <= word(reg_wdata,
                                                      stage[dwc_pkg::OFF_IBASE2],
                                                      stage[dwc_pkg::OFF_IBASE1],
                                                      stage[dwc_pkg::OFF_IBASE0]);
                end
                default: ;
            endcase
        end
    end

    assign inset0 = inset_set[0];
    assign inset1 = inset_set[1];
    assign inset_cur = inset_set[inset_sel];

    // ----------------------------------------
    // read back
    // ----------------------------------------
    // reads show committed values; staged low bytes stay hidden until the top byte lands
    always_comb begin
        case (reg_addr)
            dwc_pkg::OFF_VACT_LO: next_rdata = cfg.vact[7:0];
            dwc_pkg::OFF_VACT_HI: next_rdata = {5'h00, cfg.vact[10:8]};
            dwc_pkg::OFF_VS_START: next_rdata = cfg.vs_start;
            dwc_pkg::OFF_VS_PULSE: next_rdata = {2'b00, cfg.vs_pulse};
            dwc_pkg::OFF_MBASE0: next_rdata = cfg.main_base[7:0];
            dwc_pkg::OFF_MBASE1: next_rdata = cfg.main_base[15:8];
            dwc_pkg::OFF_MBASE2: next_rdata = cfg.main_base[23:16];
            dwc_pkg::OFF_MBASE3: next_rdata = cfg.main_base[31:24];
            dwc_pkg::OFF_MWID_LO: next_rdata = cfg.main_width[7:0];
            dwc_pkg::OFF_MWID_HI: next_rdata = {3'h0, cfg.main_width[12:8]};
            dwc_pkg::OFF_MX_LO: next_rdata = cfg.main_x[7:0];
            dwc_pkg::OFF_MX_HI: next_rdata = {3'h0, cfg.main_x[12:8]};
            dwc_pkg::OFF_MY_LO: next_rdata = cfg.main_y[7:0];
            dwc_pkg::OFF_MY_HI: next_rdata = {3'h0, cfg.main_y[12:8]};
            dwc_pkg::OFF_IX_LO: next_rdata = inset_cur.x[7:0];
            dwc_pkg::OFF_IX_HI: next_rdata = {3'h0, inset_cur.x[12:8]};
            dwc_pkg::OFF_IY_LO: next_rdata = inset_cur.y[7:0];
            dwc_pkg::OFF_IY_HI: next_rdata = {3'h0, inset_cur.y[12:8]};
            dwc_pkg::OFF_IBASE0: next_rdata = inset_cur.base[7:0];
            dwc_pkg::OFF_IBASE1: next_rdata = inset_cur.base[15:8];
            dwc_pkg::OFF_IBASE2: next_rdata = inset_cur.base[23:16];
            dwc_pkg::OFF_IBASE3: next_rdata = inset_cur.base[31:24];
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? next_rdata : 8'h00;
        end
    end

    // ----------------------------------------
    // timing and fetch
    // ----------------------------------------
    dwc_vsync u_vsync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .line_strobe(line_strobe),
        .cfg(cfg),
        .back_lines(back_lines),
        .vsync(vsync),
        .active(active),
        .line_begin(line_begin),
        .frame_start(frame_start),
        .row(row)
    );

    dwc_fetch #(
        .PIXEL_BYTES(PIXEL_BYTES)
    ) u_fetch (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .line_begin(line_begin),
        .row(row),
        .cfg(cfg),
        .row_addr(row_addr),
        .row_addr_valid(row_addr_valid)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_base_commit;
        (reg_wr && reg_addr == dwc_pkg::OFF_MBASE3) |=>
            cfg.main_base == {$past(reg_wdata), stage[dwc_pkg::OFF_MBASE2],
                              stage[dwc_pkg::OFF_MBASE1],
                              stage[dwc_pkg::OFF_MBASE0][7:2], 2'b00};
    endproperty
    a_base_commit: assert property (p_base_commit)
        else $error("main base not assembled from its four bytes");

    property p_low_hold;
        (reg_wr && reg_addr == dwc_pkg::OFF_MBASE0) |=> $stable(cfg.main_base);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low byte write changed the live main base");

    property p_inset_sel;
        (reg_wr && reg_addr == dwc_pkg::OFF_IBASE3 && inset_sel) |=>
            $stable(inset0.base) && inset1.base[31:24] == $past(reg_wdata);
    endproperty
    a_inset_sel: assert property (p_inset_sel)
        else $error("inset base write reached the unselected window");

    property p_x_commit;
        (reg_wr && reg_addr == dwc_pkg::OFF_MX_HI) |=>
            cfg.main_x[12:8] == $past(reg_wdata[4:0]) && cfg.main_x[1:0] == 2'b00;
    endproperty
    a_x_commit: assert property (p_x_commit)
        else $error("main origin x badly assembled");

    property p_y_low;
        (reg_wr && reg_addr == dwc_pkg::OFF_MY_HI) |=>
            cfg.main_y[7:0] == stage[dwc_pkg::OFF_MY_LO];
    endproperty
    a_y_low: assert property (p_y_low)
        else $error("main origin y lost its low bits");

    c_commit: cover property (reg_wr && reg_addr == dwc_pkg::OFF_MBASE3);
    c_inset1: cover property (reg_wr && reg_addr == dwc_pkg::OFF_IX_HI && inset_sel);
endmodule

// >>> dwc_panel_model.sv
// panel side model: paces lines and measures the front porch and sync segments it sees
`timescale 1ns/100ps
module dwc_panel_model (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic vsync,
    input wire logic active,
    output logic line_strobe,
    output int front_lines,
    output int sync_lines
);
    int gap;
    int run;
    int sc;
    logic vs_d;
    // ----------------
    // line pacing
    // ----------------
    // four clocks a line keeps frames short but still leaves idle cycles between strobes
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            gap <= 0;
            line_strobe <= 1'b0;
        end else begin
            gap <= (gap == 3) ? 0 : gap + 1;
            line_strobe <= (gap == 3);
        end
    end
    // ----------------
    // segment measure
    // ----------------
    // front and pulse lines
    always_ff @(posedge clk_sys) begin
        vs_d <= vsync;
        if (active) begin
            run <= 0;
        end else if (line_strobe && !vsync) begin
            run <= run + 1;
        end
        if (vsync && !vs_d) begin
            front_lines <= run;
        end
        if (vsync && line_strobe) begin
            sc <= sc + 1;
        end else if (!vsync) begin
            sc <= 0;
        end
        if (!vsync && vs_d) begin
            sync_lines <= sc;
        end
    end
endmodule

// >>> tb_display_window_config.sv
// self-checking bench for the display window configuration block
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
`define WAITC(c) begin for (int n = 0; !(c); n++) begin if (n == 4000) begin \
    bad_count++; final_report(); end @(posedge clk_sys); #1; end end
module tb_display_window_config;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic inset_sel = 1'b0;
    logic [9:0] back_lines = 10'h001;
    logic [7:0] reg_rdata;
    logic line_strobe, vsync, active, frame_start, row_addr_valid;
    logic [31:0] row_addr;
    dwc_pkg::dwc_cfg_t cfg;
    dwc_pkg::dwc_inset_t inset0, inset1;
    int front_lines, sync_lines;
    int bad_count = 0;
    int num_checks = 0;
    // small frame: 4 active lines, front 3, pulse 2, base 1000h, width 16, origin (4,2)
    // width and origin in range
    localparam logic [15:0] FR [14] = '{16'h1a03, 16'h1b00, 16'h1e02, 16'h1f01, 16'h2000,
        16'h2110, 16'h2200, 16'h2300, 16'h2410, 16'h2500, 16'h2604, 16'h2700, 16'h2802, 16'h2900};
    always #50 clk_sys = ~clk_sys;
    dwc_top #(.PIXEL_BYTES(2)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .inset_sel(inset_sel), .line_strobe(line_strobe),
        .back_lines(back_lines), .vsync(vsync), .active(active), .frame_start(frame_start),
        .row_addr(row_addr), .row_addr_valid(row_addr_valid), .cfg(cfg), .inset0(inset0),
        .inset1(inset1));
    dwc_panel_model panel_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .vsync(vsync),
        .active(active), .line_strobe(line_strobe), .front_lines(front_lines),
        .sync_lines(sync_lines));
    // ----------------
    // bus tasks
    // ----------------
    // writes leave the strobe up so back to back writes need no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic idle();
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        idle();
        `CHK(reg_rdata, e)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        rd(8'h1e, 8'h0b);
        rd(8'h1f, 8'h00);
        `CHK(cfg.vact, 11'h0df)
        `CHK(cfg.main_base, 32'h0)
        $display("test reset done");
    endtask
    task automatic t_base();
        wr(8'h20, 8'h37);
        wr(8'h21, 8'h5a);
        wr(8'h22, 8'hc3);
        idle();
        `CHK(cfg.main_base, 32'h0)
        wr(8'h23, 8'h81);
        idle();
        `CHK(cfg.main_base, 32'h81c35a34)
        rd(8'h20, 8'h34);
        wr(8'h40, 8'h55);
        rd(8'h40, 8'h00);
        $display("test base done");
    endtask
    task automatic t_fields();
        for (int i = 0; i < 6; i++) begin
            wr(8'h24 + i[7:0], (i == 3) ? 8'he3 : 8'hff);
        end
        wr(8'h1f, 8'hff);
        idle();
        `CHK(cfg.main_width, 13'h1ffc)
        `CHK(cfg.main_x, 13'h03fc)
        `CHK(cfg.main_y, 13'h1fff)
        rd(8'h25, 8'h1f);
        rd(8'h1f, 8'h3f);
        $display("test fields done");
    endtask
    task automatic t_inset();
        for (int s = 0; s < 2; s++) begin
            @(posedge clk_sys);
            reg_wr <= 1'b0;
            inset_sel <= s[0];
            for (int i = 0; i < 8; i++) begin
                wr(8'h2a + i[7:0],
                   (i == 1) ? 8'h01 : (i == 3) ? 8'h00 : {s[3:0] + 4'h1, i[3:0]});
            end
        end
        idle();
        `CHK(inset0, {13'h0110, 13'h0012, 32'h17161514})
        `CHK(inset1, {13'h0120, 13'h0022, 32'h27262524})
        rd(8'h2e, 8'h24);
        $display("test inset done");
    endtask
    task automatic t_frame();
        int rows;
        // settings land at a frame start so no running segment is overrun
        `WAITC(frame_start === 1'b1)
        for (int i = 0; i < 14; i++) begin
            wr(FR[i][15:8], FR[i][7:0]);
        end
        idle();
        `WAITC(frame_start === 1'b1)
        `WAITC(row_addr_valid === 1'b1)
        `CHK(row_addr, 32'h00001048)
        @(posedge clk_sys);
        #1;
        `WAITC(row_addr_valid === 1'b1)
        `CHK(row_addr, 32'h00001068)
        `WAITC(frame_start === 1'b1)
        rows = 0;
        for (int n = 0; vsync !== 1'b1; n++) begin
            if (n == 400) begin
                bad_count++;
                final_report();
            end
            rows += (row_addr_valid === 1'b1);
            @(posedge clk_sys);
            #1;
        end
        `CHK(rows, 4)
        `WAITC(vsync === 1'b0)
        @(posedge clk_sys);
        #1;
        `CHK(front_lines, 3)
        `CHK(sync_lines, 2)
        $display("test frame done");
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        idle();
        t_reset();
        t_base();
        t_fields();
        t_inset();
        t_frame();
        final_report();
    end
endmodule
